// File: pkg/vvs_pkg.sv
`default_nettype none
package vvs_pkg;
  // clock and timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned TRIG_LOW_NS   = 1000;
  // least time, so round up to whole cycles
  localparam int unsigned TRIG_LOW_CYC  = (TRIG_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_CNT_W    = 8;
  localparam logic [TRIG_CNT_W-1:0] TRIG_LAST = TRIG_CNT_W'(TRIG_LOW_CYC - 1);
  // session limit, counted in system ticks
  localparam int unsigned TICK_PERIOD_MS      = 10;
  localparam int unsigned SESSION_LIMIT_MIN   = 15;
  localparam int unsigned SESSION_LIMIT_TICKS = SESSION_LIMIT_MIN * 60 * 1000 / TICK_PERIOD_MS;
  localparam int unsigned TMR_W               = 32;
  // configuration codes
  localparam logic [3:0]  AUX_SEL_VOICE    = 4'h3;
  localparam logic [6:0]  RELAY_SEL_VOICE  = 7'h3C;
  localparam logic [4:0]  ZONE5_RESP_VOICE = 5'h0A;
  localparam logic [11:0] HOLD_NOTICE_CODE = 12'h606;
  // reset values
  localparam logic TRIG_IDLE = 1'b1;
  // sequencer states, gray along idle-notice-trigger-active
  typedef enum logic [2:0] {
    VVS_IDLE   = 3'h0,
    VVS_NOTICE = 3'h1,
    VVS_TRIG   = 3'h3,
    VVS_ACTIVE = 3'h2,
    VVS_FIRE   = 3'h6
  } vvs_state_t;
endpackage : vvs_pkg
`default_nettype wire

// File: pkg/vvs_tmr_if.sv
`timescale 1ns/1ns
`default_nettype none
interface vvs_tmr_if;
  logic clear;
  logic run;
  logic expired;
  modport ctrl (output clear, output run, input expired);
  modport tmr  (input clear, input run, output expired);
endinterface : vvs_tmr_if
`default_nettype wire

// File: logic/vvs_limit_timer.sv
`timescale 1ns/1ns
`default_nettype none
module vvs_limit_timer #(
  parameter int unsigned LIMIT_TICKS = vvs_pkg::SESSION_LIMIT_TICKS
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // system tick
  input  wire logic sys_tick_i,
  // control side
  vvs_tmr_if.tmr    tmr
);
  localparam logic [vvs_pkg::TMR_W-1:0] LAST = vvs_pkg::TMR_W'(LIMIT_TICKS - 1);

  logic [vvs_pkg::TMR_W-1:0] cnt_ff;
  logic [vvs_pkg::TMR_W-1:0] nxt_cnt;
  logic                      exp_ff;
  logic                      nxt_exp;

  // count ticks while a session runs; a clear restarts the window
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_exp = exp_ff;
    if (tmr.clear) begin
      nxt_cnt = '0;
      nxt_exp = 1'b0;
    end else if (tmr.run && sys_tick_i && !exp_ff) begin
      nxt_cnt = cnt_ff + 1'b1;
      nxt_exp = (cnt_ff == LAST);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= '0;
      exp_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      exp_ff <= nxt_exp;
    end
  end

  assign tmr.expired = exp_ff;
endmodule : vvs_limit_timer
`default_nettype wire

// File: logic/vvs_session_ctrl.sv
// Notes on behaviour
// - only works when alarms go to primary
// - trigger after alarm session to primary completes
// - event-code format sends hold notice 606 first
// - hand line over, keep station call up
// - mute sirens and tones while unit active
// - restore keypad tones at session end
// - restore sirens only before alarm timeout
// - force end after fifteen minutes
// - fire alarm: drop call, report, retrigger
// - hold other reports until session ends
// - trigger is a falling edge
// - zone five input marks session active
// - zone five type ten, silence option on
// - aux output select 3 or relay 60
`timescale 1ns/1ns
`default_nettype none
module vvs_session_ctrl #(
  parameter int unsigned LIMIT_TICKS = vvs_pkg::SESSION_LIMIT_TICKS
) (
  // clock, reset, tick
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  input  wire logic        sys_tick_i,
  // configuration
  input  wire logic        alarm_to_primary_i,
  input  wire logic        event_code_fmt_i,
  input  wire logic        silence_opt_i,
  input  wire logic [4:0]  zone5_resp_i,
  input  wire logic [3:0]  aux_func_sel_i,
  input  wire logic [6:0]  relay_start_sel_i,
  input  wire logic [6:0]  relay_stop_sel_i,
  // dialer
  input  wire logic        rpt_session_done_i,
  input  wire logic        rpt_had_alarm_i,
  input  wire logic        notice_ack_i,
  input  wire logic        fire_alarm_i,
  input  wire logic        fire_rpt_ack_i,
  input  wire logic        alarm_timeout_i,
  output logic             hold_line_notice_req_o,
  output logic [11:0]      hold_line_notice_code_o,
  output logic             fire_rpt_req_o,
  output logic             hold_reports_o,
  // line and voice_verify_unit
  input  wire logic        zone5_active_i,
  output logic             line_to_voice_o,
  output logic             keep_call_o,
  output logic             aux_trig_o,
  output logic             relay_trig_o,
  output logic             zone5_protect_off_o,
  // sounders
  output logic             siren_mute_o,
  output logic             tone_mute_o
);
  logic [1:0] rst_sync_ff;
  logic       rst_n;

  // reset released through two flops
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  logic zone5_meta_ff;
  logic zone5_ff;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      zone5_meta_ff <= 1'b0;
      zone5_ff      <= 1'b0;
    end else begin
      zone5_meta_ff <= zone5_active_i;
      zone5_ff      <= zone5_meta_ff;
    end
  end

  vvs_tmr_if tmr_if ();
  vvs_limit_timer #(.LIMIT_TICKS(LIMIT_TICKS)) u_timer (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n),
    .sys_tick_i (sys_tick_i),
    .tmr        (tmr_if.tmr)
  );

  vvs_pkg::vvs_state_t         state_ff, nxt_state;
  logic [vvs_pkg::TRIG_CNT_W-1:0] trig_cnt_ff, nxt_trig_cnt;
  logic seen_ff, nxt_seen;
  logic notice_ff, nxt_notice;
  logic fire_ff, nxt_fire;
  logic hold_ff, nxt_hold;
  logic line_ff, nxt_line;
  logic call_ff, nxt_call;
  logic aux_ff, nxt_aux;
  logic relay_ff, nxt_relay;
  logic siren_ff, nxt_siren;
  logic tone_ff, nxt_tone;
  logic prot_ff, nxt_prot;
  logic feature_ok;
  logic trig_low;
  logic sess_end;

  // feature usable only with alarms to primary, silence option on and zone five type ten
  assign feature_ok = alarm_to_primary_i && silence_opt_i
                    && (zone5_resp_i == vvs_pkg::ZONE5_RESP_VOICE);
  assign sess_end = (seen_ff && !zone5_ff) || tmr_if.expired;
  assign tmr_if.run = (state_ff == vvs_pkg::VVS_ACTIVE);

  // sequencer next state
  always_comb begin
    nxt_state    = state_ff;
    nxt_trig_cnt = trig_cnt_ff;
    nxt_seen     = seen_ff;
    nxt_notice   = notice_ff;
    nxt_fire     = fire_ff;
    nxt_hold     = hold_ff;
    nxt_line     = line_ff;
    nxt_call     = call_ff;
    nxt_siren    = siren_ff;
    nxt_tone     = tone_ff;
    nxt_prot     = feature_ok;
    tmr_if.clear = 1'b0;
    trig_low     = 1'b0;
    case (state_ff)
      vvs_pkg::VVS_IDLE: begin
        if (rpt_session_done_i && rpt_had_alarm_i && feature_ok) begin
          if (event_code_fmt_i) begin
            nxt_state  = vvs_pkg::VVS_NOTICE;
            nxt_notice = 1'b1;
          end else begin
            nxt_state = vvs_pkg::VVS_TRIG;
          end
        end
        // siren stays off until the alarm timeout clears
        if (!alarm_timeout_i) begin
          nxt_siren = 1'b0;
        end
      end
      vvs_pkg::VVS_NOTICE: begin
        if (notice_ack_i) begin
          nxt_notice = 1'b0;
          nxt_state  = vvs_pkg::VVS_TRIG;
        end
      end
      vvs_pkg::VVS_TRIG: begin
        // low pulse gives the unit its falling edge
        trig_low     = 1'b1;
        nxt_trig_cnt = trig_cnt_ff + 1'b1;
        // line to unit, station call held
        nxt_line     = 1'b1;
        nxt_call     = 1'b1;
        nxt_hold     = 1'b1;
        nxt_seen     = 1'b0;
        tmr_if.clear = 1'b1;
        if (trig_cnt_ff == vvs_pkg::TRIG_LAST) begin
          nxt_trig_cnt = '0;
          nxt_state    = vvs_pkg::VVS_ACTIVE;
        end
      end
      vvs_pkg::VVS_ACTIVE: begin
        nxt_seen = seen_ff || zone5_ff;
        if (zone5_ff) begin
          nxt_siren = 1'b1;
          nxt_tone  = 1'b1;
        end
        if (fire_alarm_i) begin
          // drop call and send fire report
          nxt_state = vvs_pkg::VVS_FIRE;
          nxt_line  = 1'b0;
          nxt_call  = 1'b0;
          nxt_fire  = 1'b1;
        end else if (sess_end) begin
          nxt_state = vvs_pkg::VVS_IDLE;
          nxt_line  = 1'b0;
          nxt_call  = 1'b0;
          nxt_hold  = 1'b0;
          nxt_tone  = 1'b0;
          nxt_siren = alarm_timeout_i;
        end
      end
      vvs_pkg::VVS_FIRE: begin
        // other reports stay held while the fire report goes out
        if (fire_rpt_ack_i) begin
          nxt_fire = 1'b0;
          nxt_state  = event_code_fmt_i ? vvs_pkg::VVS_NOTICE : vvs_pkg::VVS_TRIG;
          nxt_notice = event_code_fmt_i;
        end
      end
      default: begin
        nxt_state = vvs_pkg::VVS_IDLE;
      end
    endcase
    // route trigger to aux output or relay
    nxt_aux   = !(trig_low && (aux_func_sel_i == vvs_pkg::AUX_SEL_VOICE));
    nxt_relay = trig_low && (relay_start_sel_i == vvs_pkg::RELAY_SEL_VOICE)
                && (relay_stop_sel_i == vvs_pkg::RELAY_SEL_VOICE);
  end

  // sequencer registers
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_ff    <= vvs_pkg::VVS_IDLE;
      trig_cnt_ff <= '0;
      seen_ff     <= 1'b0;
      notice_ff   <= 1'b0;
      fire_ff     <= 1'b0;
      hold_ff     <= 1'b0;
      line_ff     <= 1'b0;
      call_ff     <= 1'b0;
      aux_ff      <= vvs_pkg::TRIG_IDLE;
      relay_ff    <= 1'b0;
      siren_ff    <= 1'b0;
      tone_ff     <= 1'b0;
      prot_ff     <= 1'b0;
    end else begin
      state_ff    <= nxt_state;
      trig_cnt_ff <= nxt_trig_cnt;
      seen_ff     <= nxt_seen;
      notice_ff   <= nxt_notice;
      fire_ff     <= nxt_fire;
      hold_ff     <= nxt_hold;
      line_ff     <= nxt_line;
      call_ff     <= nxt_call;
      aux_ff      <= nxt_aux;
      relay_ff    <= nxt_relay;
      siren_ff    <= nxt_siren;
      tone_ff     <= nxt_tone;
      prot_ff     <= nxt_prot;
    end
  end

  // outputs straight from flops, except the notice code, which is a constant
  assign hold_line_notice_req_o  = notice_ff;
  assign hold_line_notice_code_o = vvs_pkg::HOLD_NOTICE_CODE;
  assign fire_rpt_req_o          = fire_ff;
  assign hold_reports_o          = hold_ff;
  assign line_to_voice_o         = line_ff;
  assign keep_call_o             = call_ff;
  assign aux_trig_o              = aux_ff;
  assign relay_trig_o            = relay_ff;
  assign zone5_protect_off_o     = prot_ff;
  assign siren_mute_o            = siren_ff;
  assign tone_mute_o             = tone_ff;

  // checks on the sequencer
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  property p_no_feature;
    !feature_ok && state_ff == vvs_pkg::VVS_IDLE |=> state_ff == vvs_pkg::VVS_IDLE;
  endproperty
  a_no_feature: assert property (p_no_feature) else $error("started without feature");
  property p_start;
    state_ff == vvs_pkg::VVS_IDLE && rpt_session_done_i && rpt_had_alarm_i && feature_ok
      |=> state_ff inside {vvs_pkg::VVS_NOTICE, vvs_pkg::VVS_TRIG};
  endproperty
  a_start: assert property (p_start) else $error("no start after session");
  property p_notice;
    $rose(notice_ff) |-> $past(event_code_fmt_i) && hold_line_notice_code_o == 12'h606;
  endproperty
  a_notice: assert property (p_notice) else $error("bad notice");
  property p_line;
    line_ff |-> call_ff && hold_ff;
  endproperty
  a_line: assert property (p_line) else $error("line given without call");
  property p_mute;
    state_ff == vvs_pkg::VVS_ACTIVE && zone5_ff && !fire_alarm_i && !sess_end
      |=> siren_ff && tone_ff;
  endproperty
  a_mute: assert property (p_mute) else $error("sounders not muted");
  property p_end;
    state_ff == vvs_pkg::VVS_ACTIVE && sess_end && !fire_alarm_i
      |=> !tone_ff && !hold_ff && siren_ff == $past(alarm_timeout_i);
  endproperty
  a_end: assert property (p_end) else $error("bad session end");
  property p_limit;
    state_ff == vvs_pkg::VVS_ACTIVE && tmr_if.expired && !fire_alarm_i
      |=> state_ff == vvs_pkg::VVS_IDLE;
  endproperty
  a_limit: assert property (p_limit) else $error("limit ignored");
  property p_fire;
    state_ff == vvs_pkg::VVS_ACTIVE && fire_alarm_i |=> fire_ff && !line_ff ##1 hold_ff;
  endproperty
  a_fire: assert property (p_fire) else $error("fire not handled");
  property p_edge;
    $fell(aux_ff) |=> !aux_ff [*8];
  endproperty
  a_edge: assert property (p_edge) else $error("trigger pulse short");
  property p_aux_sel;
    aux_func_sel_i != vvs_pkg::AUX_SEL_VOICE |=> aux_ff;
  endproperty
  a_aux_sel: assert property (p_aux_sel) else $error("aux driven unselected");
  property p_clear;
    state_ff == vvs_pkg::VVS_TRIG |=> !tmr_if.expired;
  endproperty
  a_clear: assert property (p_clear) else $error("timer not cleared");

  c_session: cover property (state_ff == vvs_pkg::VVS_ACTIVE ##1 state_ff == vvs_pkg::VVS_IDLE);
  c_fire:    cover property (state_ff == vvs_pkg::VVS_FIRE ##1 state_ff != vvs_pkg::VVS_FIRE);
  c_notice:  cover property ($fell(notice_ff));
endmodule : vvs_session_ctrl
`default_nettype wire

// File: tb/vvs_unit_model.sv
`timescale 1ns/1ns
`default_nettype none
module vvs_unit_model (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        reset_n_i,
  // trigger and session timing
  input  wire logic        trig_n_i,
  input  wire logic [15:0] start_dly_i,
  input  wire logic [15:0] hold_cyc_i,
  // session indication on the zone loop
  output logic             zone5_active_o
);
  logic        trig_q_ff;
  logic        run_ff;
  logic [15:0] cnt_ff;
  // a retrigger restarts the talk time but keeps the zone high
  // falling edge start
  always @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      trig_q_ff      <= 1'b1;
      run_ff         <= 1'b0;
      cnt_ff         <= 16'h0000;
      zone5_active_o <= 1'b0;
    end else begin
      trig_q_ff <= trig_n_i;
      if (trig_q_ff && !trig_n_i) begin
        run_ff <= 1'b1;
        cnt_ff <= 16'h0000;
      end else if (run_ff) begin
        cnt_ff <= cnt_ff + 16'h0001;
        if (cnt_ff == start_dly_i) zone5_active_o <= 1'b1;
        if (cnt_ff == start_dly_i + hold_cyc_i) begin
          zone5_active_o <= 1'b0;
          run_ff         <= 1'b0;
        end
      end
    end
  end
endmodule : vvs_unit_model
`default_nettype wire

// File: tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  localparam int unsigned LIM = 20;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        tick = 1'b0;
  logic        prim = 1'b1;
  logic        evf = 1'b0;
  logic        done = 1'b0;
  logic        had = 1'b1;
  logic        nack = 1'b0;
  logic        fire = 1'b0;
  logic        fack = 1'b0;
  logic        ato = 1'b0;
  logic        sil = 1'b1;
  logic [4:0]  resp = vvs_pkg::ZONE5_RESP_VOICE;
  logic [3:0]  asel = vvs_pkg::AUX_SEL_VOICE;
  logic [6:0]  rsel = 7'h00;
  logic [15:0] sdly = 16'h0005;
  logic [15:0] hcyc = 16'h0096;
  logic        nreq, freq, hold, line, call, aux, rly, zoff, smute, tmute, z5;
  logic [11:0] ncode;
  logic        nreq_q = 1'b0, aux_q = 1'b1, rly_q = 1'b0, freq_q = 1'b0, line_q = 1'b0;
  logic [3:0]  tk;
  int          tcnt, lowc, errors, compares;
  logic [15:0] expq[$];

  vvs_session_ctrl #(.LIMIT_TICKS(LIM)) vvs_session_ctrl_inst (
    .core_clk_i(clk), .reset_n_i(rst_n), .sys_tick_i(tick),
    .alarm_to_primary_i(prim), .event_code_fmt_i(evf), .silence_opt_i(sil),
    .zone5_resp_i(resp), .aux_func_sel_i(asel), .relay_start_sel_i(rsel),
    .relay_stop_sel_i(rsel), .rpt_session_done_i(done), .rpt_had_alarm_i(had),
    .notice_ack_i(nack), .fire_alarm_i(fire), .fire_rpt_ack_i(fack),
    .alarm_timeout_i(ato), .hold_line_notice_req_o(nreq),
    .hold_line_notice_code_o(ncode), .fire_rpt_req_o(freq),
    .hold_reports_o(hold), .zone5_active_i(z5), .line_to_voice_o(line),
    .keep_call_o(call), .aux_trig_o(aux), .relay_trig_o(rly),
    .zone5_protect_off_o(zoff), .siren_mute_o(smute), .tone_mute_o(tmute));
  vvs_unit_model vvs_unit_model_inst (.core_clk_i(clk), .reset_n_i(rst_n),
    .trig_n_i(aux & ~rly), .start_dly_i(sdly), .hold_cyc_i(hcyc), .zone5_active_o(z5));

  // clock, system tick and watchdog
  initial forever #4 clk = ~clk;
  initial begin
    wait (rst_n);
    forever begin
      cyc(15);
      tick = 1'b1;
      cyc(1);
      tick = 1'b0;
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    end_sim;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask : pulse
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // a bounded wait that counts as a mismatch if it runs out
  task automatic wait_lvl(ref logic s, input logic v);
    for (int i = 0; i < 3000 && s !== v; i++) cyc(1);
    chk({15'h0000, s}, {15'h0000, v});
  endtask : wait_lvl
  task automatic ack(ref logic req, ref logic a);
    wait_lvl(req, 1'b1);
    cyc($urandom_range(0, 6));
    pulse(a);
  endtask : ack
  task automatic note_seen(input logic [15:0] got);
    chk(got, (expq.size() != 0) ? expq.pop_front() : 16'hFFFF);
  endtask : note_seen

  // event watcher: each output event takes the oldest note
  always @(posedge clk) begin
    #2;
    if (aux && !aux_q) tcnt = 0;
    else if (tick) tcnt++;
    // trigger pulse length, on the aux output or on the relay
    if (!aux || rly) lowc++;
    if ((aux && !aux_q) || (!rly && rly_q)) begin
      chk(16'(lowc), 16'(vvs_pkg::TRIG_LOW_CYC));
      lowc = 0;
    end
    if (nreq && !nreq_q) note_seen({4'h1, ncode});
    if (!aux && aux_q) note_seen({4'h2, 9'h000, hold, line, call});
    if (rly && !rly_q) note_seen({4'h3, 9'h000, hold, line, call});
    if (freq && !freq_q) note_seen({4'h4, 10'h000, line, call});
    if (!line && line_q && !freq) note_seen({4'h5, 9'h000, tmute, hold, smute});
    nreq_q = nreq;
    aux_q = aux;
    rly_q = rly;
    freq_q = freq;
    line_q = line;
  end

  // one alarm report session followed by a voice session
  task automatic session(input logic ef, input logic to, input logic fm, input logic [15:0] hc);
    evf = ef;
    ato = to;
    hcyc = hc;
    sdly = 16'($urandom_range(5, 30));
    tk = (asel == vvs_pkg::AUX_SEL_VOICE) ? 4'h2 : 4'h3;
    if (ef) expq.push_back({4'h1, vvs_pkg::HOLD_NOTICE_CODE});
    expq.push_back({tk, 12'h007});
    pulse(done);
    // station side acks the notice and keeps the call
    if (ef) ack(nreq, nack);
    wait_lvl(tmute, 1'b1);
    chk({12'h000, smute, hold, line, call}, 16'h000F);
    if (fm) begin
      expq.push_back({4'h4, 12'h000});
      if (ef) expq.push_back({4'h1, vvs_pkg::HOLD_NOTICE_CODE});
      expq.push_back({tk, 12'h007});
      pulse(fire);
      ack(freq, fack);
      if (ef) ack(nreq, nack);
    end
    expq.push_back({4'h5, 11'h000, to});
    wait_lvl(line, 1'b1);
    wait_lvl(line, 1'b0);
    if (hc > 16'h03E8) chk({15'h0000, tcnt >= LIM - 1 && tcnt <= LIM + 1}, 16'h0001);
    if (to) begin
      ato = 1'b0;
      cyc(3);
      chk({15'h0000, smute}, 16'h0000);
    end
    wait_lvl(z5, 1'b0);
    cyc(10);
  endtask : session

  task automatic end_sim;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim

  // main sequence
  initial begin
    void'($urandom(32'h8197EC63));
    cyc(5);
    rst_n = 1'b1;
    cyc(3);
    session(1'b1, 1'b0, 1'b0, 16'($urandom_range(150, 250)));
    session(1'b0, 1'b1, 1'b0, 16'($urandom_range(150, 250)));
    session(1'b1, 1'b0, 1'b1, 16'($urandom_range(150, 250)));
    asel = 4'h0;
    rsel = vvs_pkg::RELAY_SEL_VOICE;
    session(1'b0, 1'b0, 1'b0, 16'($urandom_range(150, 250)));
    asel = vvs_pkg::AUX_SEL_VOICE;
    rsel = 7'h00;
    session(1'b0, 1'b0, 1'b0, 16'h05DC);
    // misconfigured or alarm-free sessions must raise no event
    for (int k = 0; k < 4; k++) begin
      prim = (k != 0);
      had = (k != 1);
      sil = (k != 3);
      resp = (k == 2) ? 5'(vvs_pkg::ZONE5_RESP_VOICE + $urandom_range(1, 21))
                      : vvs_pkg::ZONE5_RESP_VOICE;
      cyc(4);
      chk({15'h0000, zoff}, {15'h0000, k == 1});
      pulse(done);
      cyc(300);
    end
    chk(16'(expq.size()), 16'h0000);
    end_sim;
  end
endmodule : testbench
`default_nettype wire
